// ### ebm_pkg.sv
// Constants and types for the external bus master
// What this block does
// - Accept byte, aligned half-word, aligned word only
// - 16-bit port on D[31:16], 32-bit all lines
// - Word to 16-bit port runs two cycles
// - Word transfers drive low address bits 00, then 10 in the second 16-bit port cycle
// - Unused lanes ignored on read, undefined written
// - Size code: byte 01, half 10, word 00
// - Byte lanes follow offset and port width
// - Half-word lane follows address bit 1, width
// - Strobes byte enables, write-only in WE mode
// - Strobe n marks lane n, only valid lanes
// - Read-enable asserted on every external read
// - Read first phase: address, direction high, codes
// - Read first phase: read-enable and lane strobes
// - Acknowledge ends phase, else wait phases inserted
// - Final read phase: capture data, hold outputs
// - Write first phase: address, codes, read-enable off
// - Write first phase: direction low, lane strobes
// - Write data driven from first wait phase
// - Strobes negated after final write phase
// - No chip-select active means 32-bit port
// - Acknowledge latches read data, ends cycle
// - Shortest cycle lasts two clocks: first phase and final phase
package ebm_pkg;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;
  localparam logic [1:0] SIZE_WORD = 2'h0;
  localparam int         ADDR_W    = 23;
  localparam logic [3:0] LANES_OFF = 4'hf;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_FIRST = 4'h2,
    ST_WAIT  = 4'h4,
    ST_FINAL = 4'h8
  } ebm_state_t;
endpackage

// ### ebm_master.sv
// External bus master sequencing one or two external cycles per request
module ebm_master
  import ebm_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  // Internal request
  input  wire logic              REQ_I,
  input  wire logic              REQ_WRITE_I,
  input  wire logic [1:0]        REQ_SIZE_I,
  input  wire logic [ADDR_W-1:0] REQ_ADDR_I,
  input  wire logic [2:0]        REQ_TYPE_I,
  input  wire logic [31:0]       REQ_WDATA_I,
  input  wire logic [3:0]        REQ_SELECT_I,
  output logic                   REQ_BUSY_O,
  output logic                   REQ_DONE_O,
  output logic                   REQ_ERROR_O,
  output logic [31:0]            REQ_RDATA_O,
  // Chip-select unit
  input  wire logic              CS_ACTIVE_I,
  input  wire logic              CS_PORT16_I,
  input  wire logic              CS_WE_MODE_I,
  input  wire logic              CS_ACK_I,
  // External pins
  input  wire logic              TRANSFER_ACKNOWLEDGE_N_I,
  input  wire logic [31:0]       DATA_I,
  output logic [31:0]            DATA_O,
  output logic [31:0]            DATA_OE_O,
  output logic [ADDR_W-1:0]      ADDR_O,
  output logic                   DIR_READ_O,
  output logic [1:0]             TRANSFER_WIDTH_CODE_O,
  output logic [2:0]             ACCESS_TYPE_CODE_O,
  output logic [3:0]             BYTE_LANE_STROBE_N_O,
  output logic                   READ_ENABLE_N_O,
  output logic [3:0]             DEVICE_SELECT_N_O
);

  ebm_state_t state;
  logic       ack_meta;
  logic       ack_sync;
  logic [31:0] din_meta;
  logic [31:0] din_sync;
  logic       second;
  logic       port16;
  logic       we_mode;
  logic       is_write;
  logic [1:0] size;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic       req_ok;
  logic       ack;
  logic       split;
  logic [1:0] cyc_size;
  logic [1:0] cyc_a;
  logic [3:0] lanes;
  logic [31:0] placed;

  // Pin synchronisers
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
      din_meta <= 32'h0;
      din_sync <= 32'h0;
    end else begin
      ack_meta <= !TRANSFER_ACKNOWLEDGE_N_I;
      ack_sync <= ack_meta;
      din_meta <= DATA_I;
      din_sync <= din_meta;
    end
  end

  assign ack = ack_sync | CS_ACK_I;

  // Request legality: no misaligned operand
  always_comb begin
    case (REQ_SIZE_I)
      SIZE_BYTE: req_ok = 1'b1;
      SIZE_HALF: req_ok = (REQ_ADDR_I[0] == 1'b0);
      SIZE_WORD: req_ok = (REQ_ADDR_I[1:0] == 2'h0);
      default:   req_ok = 1'b0;
    endcase
  end

  assign split = (size == SIZE_WORD) && port16;

  // Cycle size code and low address bits
  always_comb begin
    if (split && second) begin
      cyc_size = SIZE_HALF;
      cyc_a    = 2'h2;
    end else if (size == SIZE_WORD) begin
      cyc_size = SIZE_WORD;
      cyc_a    = 2'h0;
    end else begin
      cyc_size = size;
      cyc_a    = addr[1:0];
    end
  end

  // Lane strobes and write data placement
  always_comb begin
    lanes  = 4'h0;
    placed = 32'h0;
    if (cyc_size == SIZE_BYTE) begin
      if (port16) begin
        lanes[{1'b0, cyc_a[0]}] = 1'b1;
        placed = cyc_a[0] ? {8'h0, wdata[7:0], 16'h0} : {wdata[7:0], 24'h0};
      end else begin
        lanes[cyc_a] = 1'b1;
        placed = 32'(wdata[7:0]) << (8 * (3 - cyc_a));
      end
    end else if (cyc_size == SIZE_HALF && !(split && second)) begin
      if (cyc_a[1] && !port16) begin
        lanes  = 4'hc;
        placed = {16'h0, wdata[15:0]};
      end else begin
        lanes  = 4'h3;
        placed = {wdata[15:0], 16'h0};
      end
    end else if (port16) begin
      lanes  = 4'h3;
      placed = second ? {wdata[15:0], 16'h0} : {wdata[31:16], 16'h0};
    end else begin
      lanes  = 4'hf;
      placed = wdata;
    end
  end

  // Request capture and sequence
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state    <= ST_IDLE;
      second   <= 1'b0;
      port16   <= 1'b0;
      we_mode  <= 1'b0;
      is_write <= 1'b0;
      size     <= SIZE_WORD;
      addr     <= '0;
      wdata    <= 32'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          second <= 1'b0;
          if (REQ_I && req_ok) begin
            state    <= ST_FIRST;
            port16   <= CS_ACTIVE_I & CS_PORT16_I;
            we_mode  <= CS_ACTIVE_I & CS_WE_MODE_I;
            is_write <= REQ_WRITE_I;
            size     <= REQ_SIZE_I;
            addr     <= REQ_ADDR_I;
            wdata    <= REQ_WDATA_I;
          end
        end
        ST_FIRST: state <= ack ? ST_FINAL : ST_WAIT;
        ST_WAIT:  state <= ack ? ST_FINAL : ST_WAIT;
        ST_FINAL: begin
          if (split && !second) begin
            second <= 1'b1;
            state  <= ST_FIRST;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // External pin drive
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ADDR_O                <= '0;
      DIR_READ_O            <= 1'b1;
      TRANSFER_WIDTH_CODE_O <= SIZE_WORD;
      ACCESS_TYPE_CODE_O    <= 3'h0;
      BYTE_LANE_STROBE_N_O  <= LANES_OFF;
      READ_ENABLE_N_O       <= 1'b1;
      DEVICE_SELECT_N_O     <= 4'hf;
      DATA_O                <= 32'h0;
      DATA_OE_O             <= 32'h0;
    end else if (state == ST_IDLE && REQ_I && req_ok) begin
      ADDR_O                <= REQ_ADDR_I;
      ACCESS_TYPE_CODE_O    <= REQ_TYPE_I;
      DEVICE_SELECT_N_O     <= ~REQ_SELECT_I;
      DIR_READ_O            <= 1'b1;
      READ_ENABLE_N_O       <= 1'b1;
      BYTE_LANE_STROBE_N_O  <= LANES_OFF;
      TRANSFER_WIDTH_CODE_O <= REQ_SIZE_I;
      DATA_OE_O             <= 32'h0;
    end else if (state == ST_FIRST) begin
      ADDR_O[1:0]           <= cyc_a;
      TRANSFER_WIDTH_CODE_O <= cyc_size;
      DIR_READ_O            <= !is_write;
      READ_ENABLE_N_O       <= is_write;
      BYTE_LANE_STROBE_N_O  <= (is_write || !we_mode) ? ~lanes : LANES_OFF;
      DATA_O                <= placed;
      DATA_OE_O             <= is_write ? 32'hffffffff : 32'h0;
    end else if (state == ST_FINAL) begin
      BYTE_LANE_STROBE_N_O  <= LANES_OFF;
      READ_ENABLE_N_O       <= 1'b1;
      DATA_OE_O             <= 32'h0;
      if (!(split && !second)) begin
        DEVICE_SELECT_N_O <= 4'hf;
      end
    end
  end

  // Read data capture and completion
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      REQ_RDATA_O <= 32'h0;
      REQ_DONE_O  <= 1'b0;
      REQ_ERROR_O <= 1'b0;
      REQ_BUSY_O  <= 1'b0;
    end else begin
      REQ_DONE_O  <= (state == ST_FINAL) && !(split && !second);
      REQ_ERROR_O <= (state == ST_IDLE) && REQ_I && !req_ok;
      REQ_BUSY_O  <= (state == ST_IDLE) ? (REQ_I && req_ok) :
                     !((state == ST_FINAL) && !(split && !second));
      if (state == ST_FINAL && !is_write) begin
        if (split && !second) begin
          REQ_RDATA_O[31:16] <= din_sync[31:16];
        end else if (split) begin
          REQ_RDATA_O[15:0] <= din_sync[31:16];
        end else if (size == SIZE_BYTE) begin
          REQ_RDATA_O <= {24'h0, port16 ? (addr[0] ? din_sync[23:16] : din_sync[31:24])
                                        : 8'(din_sync >> (8 * (3 - addr[1:0])))};
        end else if (size == SIZE_HALF) begin
          REQ_RDATA_O <= {16'h0, (addr[1] && !port16) ? din_sync[15:0] : din_sync[31:16]};
        end else begin
          REQ_RDATA_O <= din_sync;
        end
      end
    end
  end

  a_split_second_half: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_FINAL && split && second) |-> (TRANSFER_WIDTH_CODE_O == SIZE_HALF
      && ADDR_O[1:0] == 2'h2)) else $error("Second split cycle codes wrong");
  a_read_enable_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_WAIT && !is_write) |-> !READ_ENABLE_N_O) else $error("Read-enable off in read");
  a_write_no_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_WAIT && is_write) |-> (READ_ENABLE_N_O && !DIR_READ_O))
    else $error("Write cycle drove read-enable");
  a_final_after_ack: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state inside {ST_FIRST, ST_WAIT} && ack) |=> state == ST_FINAL)
    else $error("Acknowledge did not end cycle");
  a_strobes_released: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_FINAL) |=> BYTE_LANE_STROBE_N_O == LANES_OFF) else $error("Strobes left on");
  a_done_after_final: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    REQ_DONE_O |-> $past(state == ST_FINAL)) else $error("Done without final phase");
  a_word_low_bits: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_WAIT && size == SIZE_WORD && !second) |-> ADDR_O[1:0] == 2'h0)
    else $error("Word address low bits set");
  a_write_data_on: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_WAIT && is_write) |-> DATA_OE_O == 32'hffffffff) else $error("Write data off");

  a_refuse_no_cycle: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    REQ_ERROR_O |-> (state == ST_IDLE && READ_ENABLE_N_O
      && BYTE_LANE_STROBE_N_O == LANES_OFF))
    else $error("Refused request started a cycle");
  a_idle_released: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_IDLE) |-> (DATA_OE_O == 32'h0 && READ_ENABLE_N_O
      && BYTE_LANE_STROBE_N_O == LANES_OFF && DEVICE_SELECT_N_O == 4'hf))
    else $error("Bus not released in idle");
  a_read_dir_high: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state inside {ST_WAIT, ST_FINAL} && !is_write) |-> DIR_READ_O)
    else $error("Direction low in read");
  a_word_size_code: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_WAIT && size == SIZE_WORD && !second)
      |-> TRANSFER_WIDTH_CODE_O == SIZE_WORD)
    else $error("Word size code wrong");
  a_we_mode_reads: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_WAIT && !is_write && we_mode) |-> BYTE_LANE_STROBE_N_O == LANES_OFF)
    else $error("Strobes on in write-enable mode read");
  a_write_strobes_on: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_WAIT && is_write) |-> BYTE_LANE_STROBE_N_O != LANES_OFF)
    else $error("Write cycle without strobes");
  a_done_single: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    REQ_DONE_O |=> !REQ_DONE_O)
    else $error("Done longer than one cycle");
  a_busy_in_cycle: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state inside {ST_FIRST, ST_WAIT, ST_FINAL}) |-> REQ_BUSY_O)
    else $error("Busy low during a cycle");
  a_split_first_word: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state inside {ST_WAIT, ST_FINAL} && split && !second)
      |-> (TRANSFER_WIDTH_CODE_O == SIZE_WORD && ADDR_O[1:0] == 2'h0))
    else $error("First split cycle codes wrong");
  a_codes_stable: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_WAIT) |=> ($stable(ADDR_O) && $stable(TRANSFER_WIDTH_CODE_O)
      && $stable(ACCESS_TYPE_CODE_O) && $stable(DEVICE_SELECT_N_O) && $stable(DIR_READ_O)))
    else $error("Cycle outputs moved in wait phase");
  a_final_one_cycle: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_FINAL) |=> (state != ST_FINAL))
    else $error("Final phase longer than one cycle");
  a_read_lines_free: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == ST_WAIT && !is_write) |-> DATA_OE_O == 32'h0)
    else $error("Data driven during read");

  c_one_clock: cover property (@(posedge CLK_I) state == ST_FIRST ##1 state == ST_FINAL);
  c_waited: cover property (@(posedge CLK_I) state == ST_WAIT ##1 state == ST_FINAL);
  c_split: cover property (@(posedge CLK_I) split && second && state == ST_FINAL);
  c_refused: cover property (@(posedge CLK_I) REQ_ERROR_O);
  c_we_read: cover property (@(posedge CLK_I) state == ST_WAIT && we_mode && !is_write);

endmodule

// ### ebm_slave_model.sv
// Behavioural external memory answering the master's bus pins
module ebm_slave_model
  import ebm_pkg::*;
(
  // Bus from the master
  input  wire logic              clk_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [31:0]       data_i,
  input  wire logic [31:0]       data_oe_i,
  input  wire logic [3:0]        strobe_n_i,
  input  wire logic              read_en_n_i,
  // Test controls
  input  wire logic              port16_i,
  input  wire logic              pin_ack_i,
  input  wire logic [3:0]        waits_i,
  // Answers
  output logic [31:0]            data_o,
  output logic                   ack_n_o,
  output logic                   cs_ack_o
);
  logic [7:0]  mem [256];
  logic [3:0]  cnt;
  logic        acked;
  logic [31:0] last = 32'h0;
  logic [31:0] rd;
  wire         act = !read_en_n_i || !(&strobe_n_i);
  always_comb begin
    rd = {mem[{addr_i[7:2], 2'h0}], mem[{addr_i[7:2], 2'h1}],
          mem[{addr_i[7:2], 2'h2}], mem[{addr_i[7:2], 2'h3}]};
    if (port16_i) rd = addr_i[1] ? {rd[15:0], ~rd[15:0]} : {rd[31:16], ~rd[31:16]};
    data_o = read_en_n_i ? ~last : rd;
  end
  always_ff @(posedge clk_i) begin
    last <= data_o;
    cs_ack_o <= 1'b0;
    ack_n_o <= 1'b1;
    cnt <= act ? cnt + 4'h1 : 4'h0;
    if (!act) acked <= 1'b0;
    else if (!acked && cnt == waits_i) begin
      acked <= 1'b1;
      ack_n_o <= !pin_ack_i;
      cs_ack_o <= !pin_ack_i;
    end
    for (int k = 0; k < 4; k++)
      if (!strobe_n_i[k] && data_oe_i[31-8*k])
        mem[{addr_i[7:2], port16_i ? {addr_i[1], 1'(k)} : 2'(k)}] <= data_i[31-8*k -: 8];
  end
endmodule

// ### ebm_master_tb_top.sv
// Self-checking bench for the external bus master
module ebm_master_tb_top;
  import ebm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 0, rst_n = 0, req = 0, wr = 0, cs_act = 0, cs_p16 = 0, cs_we = 0;
  logic              pin = 0, busy, done, err, cs_ack, ack_n, dir, re_n;
  logic [1:0]        sz = 0, wcode;
  logic [2:0]        tcode;
  logic [3:0]        waits = 0, stb_n, sel_n;
  logic [ADDR_W-1:0] addr_q = 0, addr;
  logic [31:0]       wd = 0, rdata, din, dout, doe, rd;
  int                n_mismatch = 0, tests_run = 0, cycles = 0;

  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  ebm_master DUT (.CLK_I(clk), .RST_N_I(rst_n), .REQ_I(req), .REQ_WRITE_I(wr), .REQ_SIZE_I(sz),
    .REQ_ADDR_I(addr_q), .REQ_TYPE_I({wr, sz}), .REQ_WDATA_I(wd), .REQ_SELECT_I(4'h5),
    .REQ_BUSY_O(busy), .REQ_DONE_O(done), .REQ_ERROR_O(err), .REQ_RDATA_O(rdata),
    .CS_ACTIVE_I(cs_act), .CS_PORT16_I(cs_p16), .CS_WE_MODE_I(cs_we), .CS_ACK_I(cs_ack),
    .TRANSFER_ACKNOWLEDGE_N_I(ack_n), .DATA_I(din), .DATA_O(dout), .DATA_OE_O(doe),
    .ADDR_O(addr), .DIR_READ_O(dir), .TRANSFER_WIDTH_CODE_O(wcode),
    .ACCESS_TYPE_CODE_O(tcode), .BYTE_LANE_STROBE_N_O(stb_n), .READ_ENABLE_N_O(re_n),
    .DEVICE_SELECT_N_O(sel_n));
  ebm_slave_model slave (.clk_i(clk), .addr_i(addr), .data_i(dout), .data_oe_i(doe),
    .strobe_n_i(stb_n), .read_en_n_i(re_n), .port16_i(cs_act & cs_p16), .pin_ack_i(pin),
    .waits_i(waits), .data_o(din), .ack_n_o(ack_n), .cs_ack_o(cs_ack));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [3:0] lanes(logic [1:0] s, logic [1:0] a, logic p, logic we, logic w);
    if (we && !w) return 4'h0;
    if (s == SIZE_BYTE) return p ? 4'h1 << a[0] : 4'h1 << a;
    if (s == SIZE_HALF) return (a[1] && !p) ? 4'hc : 4'h3;
    return p ? 4'h3 : 4'hf;
  endfunction

  // cfg is {chip-select active, 16-bit port, write-enable mode, pin acknowledge}
  task automatic xfer(input logic w, input logic [1:0] s, input logic [7:0] ad,
                      input logic [31:0] d, input logic [3:0] cfg, input logic [3:0] nw);
    logic split, bad, on, was;
    logic [3:0] m, ex;
    int nc, n;
    split = s == SIZE_WORD && cfg[3] && cfg[2];
    bad = (s == SIZE_HALF && ad[0]) || (s == SIZE_WORD && ad[1:0] != 2'h0);
    nc = 0;
    n = 0;
    was = 0;
    m = 0;
    ex = lanes(s, ad[1:0], cfg[3] & cfg[2], cfg[3] & cfg[1], w);
    @(negedge clk);
    {req, wr, sz, addr_q, wd} = {1'b1, w, s, 15'h0, ad, d};
    {cs_act, cs_p16, cs_we, pin} = cfg;
    waits = nw;
    @(negedge clk);
    req = 0;
    while (done !== 1'b1 && err !== 1'b1 && n < 40) begin
      on = !re_n || !(&stb_n);
      check(busy, 1'b1);
      if (on && !was) begin
        check(wcode, split && nc == 1 ? SIZE_HALF : s);
        check(addr[1:0], split && nc == 1 ? 2'h2 : ad[1:0]);
        check({dir, tcode, sel_n}, {!w, w, s, 4'ha});
        m = 0;
        nc++;
      end
      if (on) m = m | ~stb_n;
      if (!on && was) check(m, ex);
      if (on && !w) check(re_n, 1'b0);
      if (w) check(re_n, 1'b1);
      was = on;
      n++;
      @(negedge clk);
    end
    if (n == 40) check(0, 1);
    if (was) check(m, ex);
    check({err, 2'(nc)}, {bad, bad ? 2'h0 : split ? 2'h2 : 2'h1});
    check({stb_n, re_n, busy}, 6'h3e);
    rd = rdata;
  endtask

  task automatic t_reset();
    check({stb_n, re_n, sel_n, dir}, 10'h3ff);
    check(doe, 32'h0);
  endtask

  task automatic t_split();
    xfer(1, SIZE_WORD, 8'h10, 32'h11223344, 4'hc, 0);
    xfer(0, SIZE_WORD, 8'h10, 0, 4'hc, 1);
    check(rd, 32'h11223344);
    xfer(0, SIZE_WORD, 8'h10, 0, 4'h8, 2);
    check(rd, 32'h11223344);
    xfer(0, SIZE_WORD, 8'h10, 0, 4'h5, 1);
    check(rd, 32'h11223344);
  endtask

  task automatic t_lanes();
    for (int p = 0; p < 2; p++)
      for (int o = 0; o < 4; o++) begin
        xfer(0, SIZE_BYTE, 8'(8'h10 + o), 0, {1'b1, 1'(p), 2'h0}, 0);
        check(rd[7:0], 8'(8'h11 * (o + 1)));
        if (o % 2 == 0) begin
          xfer(0, SIZE_HALF, 8'(8'h10 + o), 0, {1'b1, 1'(p), 2'h1}, 1);
          check(rd[15:0], o == 2 ? 16'h3344 : 16'h1122);
        end
      end
  endtask

  task automatic t_writes();
    for (int o = 0; o < 4; o++) xfer(1, SIZE_BYTE, 8'(8'h20 + o), 32'(8'ha0 + o), 4'hd, 1);
    xfer(1, SIZE_HALF, 8'h26, 32'h5566, 4'h8, 3);
    xfer(1, SIZE_HALF, 8'h24, 32'h7788, 4'hd, 0);
    xfer(0, SIZE_WORD, 8'h20, 0, 4'h0, 3);
    check(rd, 32'ha0a1a2a3);
    xfer(0, SIZE_WORD, 8'h24, 0, 4'h1, 0);
    check(rd, 32'h77885566);
  endtask

  task automatic t_we_mode();
    xfer(0, SIZE_HALF, 8'h22, 0, 4'ha, 1);
    check(rd[15:0], 16'ha2a3);
    xfer(1, SIZE_BYTE, 8'h23, 32'h5a, 4'ha, 0);
    xfer(0, SIZE_BYTE, 8'h23, 0, 4'h0, 0);
    check(rd[7:0], 8'h5a);
  endtask

  task automatic t_refused();
    xfer(0, SIZE_HALF, 8'h11, 0, 4'h8, 0);
    xfer(1, SIZE_WORD, 8'h12, 32'hffff, 4'hc, 0);
  endtask

  initial begin
    repeat (4) @(negedge clk);
    t_reset();
    rst_n = 1;
    t_split();
    t_lanes();
    t_writes();
    t_we_mode();
    t_refused();
    report_and_stop();
  end
endmodule
